// ==== core/sgp_pkg.sv ====
// Shared constants, types and state layouts for the serializer pin port.
package sgp_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] SGP_ADDR_LOCAL_DATA = 8'h0D;
  localparam logic [7:0] SGP_ADDR_DIR_CTRL = 8'h0E;
  localparam logic [7:0] SGP_ADDR_PIN_LEVEL = 8'h53;
  localparam logic [7:0] SGP_ADDR_FWD_CFG = 8'h30;
  localparam logic [7:0] SGP_ADDR_SENSE_CTRL = 8'h31;
  localparam logic [7:0] SGP_ADDR_CLK_MODE = 8'h32;

  localparam logic [7:0] SGP_LOCAL_DATA_RST = 8'h00;
  localparam logic [7:0] SGP_DIR_CTRL_RST = 8'h0F;
  localparam logic [2:0] SGP_FWD_CFG_RST = 3'h0;
  localparam logic [1:0] SGP_SENSE_RST = 2'h0;
  localparam logic [7:0] SGP_ZERO_BYTE = 8'h00;

  // Field positions inside the byte-wide registers.
  localparam int SGP_NPIN = 4;
  localparam int SGP_IN_EN_LSB = 0;
  localparam int SGP_OUT_EN_LSB = 4;
  localparam int SGP_LDATA_LSB = 0;
  localparam int SGP_RMT_EN_LSB = 4;
  localparam int SGP_FWD_CNT_LSB = 0;
  localparam int SGP_SENSE_LSB = 0;

  // ==========================================================================
  // Link framing and forward sampling
  // ==========================================================================
  localparam int SGP_FWD_FRAME_BITS = 40;
  localparam int SGP_BCK_FRAME_BITS = 30;
  localparam logic [2:0] SGP_FWD_PER_ONE = 3'h1;
  localparam logic [2:0] SGP_FWD_PER_TWO = 3'h2;
  localparam logic [2:0] SGP_FWD_PER_FIVE = 3'h5;
  localparam logic [2:0] SGP_CNT_NONE = 3'h0;
  localparam logic [2:0] SGP_CNT_ONE = 3'h1;
  localparam logic [2:0] SGP_CNT_TWO = 3'h2;
  localparam logic [2:0] SGP_CNT_MAX = 3'h4;
  localparam logic [2:0] SGP_FRM_STEP = 3'h1;
  localparam int SGP_FWD_LATENCY_NS = 225;

  // ==========================================================================
  // Clocking modes and back-link sampling
  // ==========================================================================
  typedef enum logic [1:0] {
    SGP_CLK_SYNC,
    SGP_CLK_NONSYNC,
    SGP_CLK_DVP
  } sgp_clk_mode_t;

  localparam logic [2:0] SGP_STRAP_SYNC = 3'h0;
  localparam logic [2:0] SGP_STRAP_DVP = 3'h5;
  localparam logic [1:0] SGP_STRAP_SETTLE = 2'h3;
  localparam logic [1:0] SGP_STRAP_STEP = 2'h1;

  localparam int SGP_MCLK_HZ = 10_000_000;
  localparam int SGP_MCLK_PERIOD_NS = 1_000_000_000 / SGP_MCLK_HZ;
  // Sampling rates in tenths of a kilohertz.
  localparam int SGP_BCK_SYNC_DKHZ = 16700;
  localparam int SGP_BCK_NONSYNC_DKHZ = 3340;
  localparam int SGP_BCK_DVP_DKHZ = 835;
  localparam int SGP_DKHZ_TO_NS = 10_000_000;
  localparam int SGP_BCK_FRAME_NS = 600;
  localparam logic [7:0] SGP_BCK_SYNC_CYC =
    8'((SGP_DKHZ_TO_NS / SGP_BCK_SYNC_DKHZ) / SGP_MCLK_PERIOD_NS);
  localparam logic [7:0] SGP_BCK_NONSYNC_CYC =
    8'((SGP_DKHZ_TO_NS / SGP_BCK_NONSYNC_DKHZ) / SGP_MCLK_PERIOD_NS);
  localparam logic [7:0] SGP_BCK_DVP_CYC =
    8'((SGP_DKHZ_TO_NS / SGP_BCK_DVP_DKHZ) / SGP_MCLK_PERIOD_NS);
  localparam logic [7:0] SGP_CNT_STEP = 8'h01;
  localparam logic [7:0] SGP_CNT_ZERO = 8'h00;

  // ==========================================================================
  // Carriers and state
  // ==========================================================================
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgp_reg_req_t;

  typedef struct packed {
    logic vld;
    logic [1:0] idx;
    logic level;
  } sgp_fwd_slot_t;

  typedef struct packed {
    logic vld;
    logic [3:0] pins;
  } sgp_bck_frame_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sgp_sync_st_t;

  typedef struct packed {
    logic [3:0] in_en;
    logic [2:0] cnt;
  } sgp_fwd_cfg_t;

  typedef struct packed {
    logic [7:0] local_data;
    logic [7:0] dir_ctrl;
    logic [2:0] fwd_cnt;
    logic [1:0] sense;
    sgp_clk_mode_t clk_mode;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [7:0] bck_cnt;
    logic [3:0] rmt;
    logic [7:0] rdata;
    logic rvld;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
    logic [1:0] sense_en;
    sgp_fwd_cfg_t xfer_word;
    logic xfer_req;
  } sgp_main_st_t;

  typedef struct packed {
    logic [2:0] frm;
    logic [3:0] shadow;
    sgp_fwd_slot_t slot;
    logic [3:0] rmt;
    sgp_fwd_cfg_t cfg;
    logic xfer_ack;
  } sgp_link_st_t;

endpackage : sgp_pkg

// ==== core/sgp_sync.sv ====
// Two-stage synchroniser for a four-bit level bus.
`timescale 1ns/1ps
module sgp_sync
  import sgp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] d,
  output logic [3:0] q
);

  // ==========================================================================
  // State
  // ==========================================================================
  sgp_sync_st_t st_q;
  sgp_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : sgp_sync

// ==== core/sgp_port.sv ====
// Four-pin general purpose port with forward and back link pin channels.
`timescale 1ns/1ps

module sgp_port
  import sgp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic lnk_clk,
  input sgp_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvld,
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe,
  output logic [1:0] volt_sense_en,
  input wire logic [2:0] mode_strap,
  output sgp_clk_mode_t clk_mode,
  input wire logic fwd_frame_tick,
  output sgp_fwd_slot_t fwd_slot,
  input sgp_bck_frame_t bck_frame
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [2:0] sgp_fwd_period(input logic [2:0] cnt);
    logic [2:0] per;
    per = SGP_FWD_PER_FIVE;
    if (cnt <= SGP_CNT_ONE) begin
      per = SGP_FWD_PER_ONE;
    end else if (cnt == SGP_CNT_TWO) begin
      per = SGP_FWD_PER_TWO;
    end
    return per;
  endfunction : sgp_fwd_period

  function automatic logic [7:0] sgp_bck_cycles(input sgp_clk_mode_t mode);
    logic [7:0] cyc;
    cyc = SGP_BCK_SYNC_CYC;
    unique case (mode)
      SGP_CLK_SYNC: cyc = SGP_BCK_SYNC_CYC;
      SGP_CLK_NONSYNC: cyc = SGP_BCK_NONSYNC_CYC;
      SGP_CLK_DVP: cyc = SGP_BCK_DVP_CYC;
      default: cyc = SGP_BCK_SYNC_CYC;
    endcase
    return cyc;
  endfunction : sgp_bck_cycles

  function automatic sgp_clk_mode_t sgp_strap_decode(input logic [2:0] strap);
    sgp_clk_mode_t mode;
    mode = SGP_CLK_NONSYNC;
    if (strap == SGP_STRAP_SYNC) begin
      mode = SGP_CLK_SYNC;
    end else if (strap == SGP_STRAP_DVP) begin
      mode = SGP_CLK_DVP;
    end
    return mode;
  endfunction : sgp_strap_decode

  // ==========================================================================
  // Crossings
  // ==========================================================================
  sgp_main_st_t st_q;
  sgp_main_st_t st_d;
  sgp_link_st_t ln_q;
  sgp_link_st_t ln_d;

  logic [3:0] pin_s;
  logic [3:0] rmt_s;
  logic [3:0] strap_s;
  logic [3:0] pin_l;
  logic [3:0] req_l;
  logic [3:0] ack_m;

  sgp_sync u_sync_pin (
    .clk(mclk),
    .arst_n(arst_n),
    .d(pin_i),
    .q(pin_s)
  );

  sgp_sync u_sync_rmt (
    .clk(mclk),
    .arst_n(arst_n),
    .d(ln_q.rmt),
    .q(rmt_s)
  );

  sgp_sync u_sync_strap (
    .clk(mclk),
    .arst_n(arst_n),
    .d({1'b0, mode_strap}),
    .q(strap_s)
  );

  sgp_sync u_sync_pin_lnk (
    .clk(lnk_clk),
    .arst_n(arst_n),
    .d(pin_i),
    .q(pin_l)
  );

  sgp_sync u_sync_req_lnk (
    .clk(lnk_clk),
    .arst_n(arst_n),
    .d({3'h0, st_q.xfer_req}),
    .q(req_l)
  );

  sgp_sync u_sync_ack (
    .clk(mclk),
    .arst_n(arst_n),
    .d({3'h0, ln_q.xfer_ack}),
    .q(ack_m)
  );

  // ==========================================================================
  // Register and pin logic on the main clock
  // ==========================================================================
  logic [3:0] out_en;
  logic [3:0] rmt_en;
  logic [3:0] ldata;
  sgp_fwd_cfg_t fwd_cfg;

  always_comb begin
    st_d = st_q;
    st_d.rvld = 1'b0;

    // The strap is taken once, after the synchroniser has filled.
    if (!st_q.strap_done) begin
      if (st_q.strap_wait == SGP_STRAP_SETTLE) begin
        st_d.clk_mode = sgp_strap_decode(strap_s[2:0]);
        st_d.strap_done = 1'b1;
      end else begin
        st_d.strap_wait = st_q.strap_wait + SGP_STRAP_STEP;
      end
    end

    // Back-link pin data is resampled at the rate of the clocking mode.
    if (st_q.bck_cnt == SGP_CNT_ZERO) begin
      st_d.bck_cnt = sgp_bck_cycles(st_q.clk_mode) - SGP_CNT_STEP;
      st_d.rmt = rmt_s;
    end else begin
      st_d.bck_cnt = st_q.bck_cnt - SGP_CNT_STEP;
    end

    if (reg_req.we) begin
      unique case (reg_req.addr)
        SGP_ADDR_LOCAL_DATA: st_d.local_data = reg_req.wdata;
        SGP_ADDR_DIR_CTRL: st_d.dir_ctrl = reg_req.wdata;
        SGP_ADDR_FWD_CFG: begin
          if (reg_req.wdata[SGP_FWD_CNT_LSB +: 3] <= SGP_CNT_MAX) begin
            st_d.fwd_cnt = reg_req.wdata[SGP_FWD_CNT_LSB +: 3];
          end else begin
            st_d.fwd_cnt = SGP_CNT_MAX;
          end
        end
        SGP_ADDR_SENSE_CTRL: st_d.sense = reg_req.wdata[SGP_SENSE_LSB +: 2];
        default: begin
        end
      endcase
    end

    if (reg_req.re) begin
      st_d.rvld = 1'b1;
      unique case (reg_req.addr)
        SGP_ADDR_LOCAL_DATA: st_d.rdata = st_q.local_data;
        SGP_ADDR_DIR_CTRL: st_d.rdata = st_q.dir_ctrl;
        SGP_ADDR_PIN_LEVEL: st_d.rdata = {4'h0, pin_s};
        SGP_ADDR_FWD_CFG: st_d.rdata = {5'h00, st_q.fwd_cnt};
        SGP_ADDR_SENSE_CTRL: st_d.rdata = {6'h00, st_q.sense};
        SGP_ADDR_CLK_MODE: st_d.rdata = {6'h00, st_q.clk_mode};
        default: st_d.rdata = SGP_ZERO_BYTE;
      endcase
    end

    // Output enable wins should both enables be set for a pin.
    out_en = st_q.dir_ctrl[SGP_OUT_EN_LSB +: SGP_NPIN];
    rmt_en = st_q.local_data[SGP_RMT_EN_LSB +: SGP_NPIN];
    ldata = st_q.local_data[SGP_LDATA_LSB +: SGP_NPIN];
    st_d.pin_oe = out_en;
    // Remote-enabled pins drive the resampled back-link levels; the others drive local data.
    st_d.pin_o = (rmt_en & st_q.rmt) | (~rmt_en & ldata);
    st_d.sense_en = st_q.sense & ~out_en[1:0];

    // Forward settings cross as one word under a toggle handshake.
    // The word holds still until the link side echoes the toggle.
    fwd_cfg.in_en = st_q.dir_ctrl[SGP_IN_EN_LSB +: SGP_NPIN];
    fwd_cfg.cnt = st_q.fwd_cnt;
    if (ack_m[0] == st_q.xfer_req && fwd_cfg != st_q.xfer_word) begin
      st_d.xfer_word = fwd_cfg;
      st_d.xfer_req = ~st_q.xfer_req;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.local_data <= SGP_LOCAL_DATA_RST;
      st_q.dir_ctrl <= SGP_DIR_CTRL_RST;
      st_q.fwd_cnt <= SGP_FWD_CFG_RST;
      st_q.sense <= SGP_SENSE_RST;
      st_q.clk_mode <= SGP_CLK_SYNC;
      st_q.strap_wait <= '0;
      st_q.strap_done <= 1'b0;
      st_q.bck_cnt <= SGP_CNT_ZERO;
      st_q.rmt <= '0;
      st_q.rdata <= SGP_ZERO_BYTE;
      st_q.rvld <= 1'b0;
      st_q.pin_o <= '0;
      st_q.pin_oe <= '0;
      st_q.sense_en <= '0;
      st_q.xfer_word <= '0;
      st_q.xfer_req <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvld = st_q.rvld;
  assign pin_o = st_q.pin_o;
  assign pin_oe = st_q.pin_oe;
  assign volt_sense_en = st_q.sense_en;
  assign clk_mode = st_q.clk_mode;

  // ==========================================================================
  // Link-side framing on the link clock
  // ==========================================================================
  logic [2:0] per_l;
  logic [2:0] cnt_l;
  logic [3:0] fwd_pins;

  always_comb begin
    ln_d = ln_q;
    if (req_l[0] != ln_q.xfer_ack) begin
      ln_d.cfg = st_q.xfer_word;
      ln_d.xfer_ack = req_l[0];
    end
    cnt_l = ln_q.cfg.cnt;
    per_l = sgp_fwd_period(cnt_l);
    fwd_pins = pin_l & ln_q.cfg.in_en;

    if (fwd_frame_tick) begin
      // One slot per forward frame; the first slot of a period samples all input-enabled pins.
      if (ln_q.frm == '0 || ln_q.frm >= per_l) begin
        ln_d.shadow = fwd_pins;
        ln_d.slot.level = fwd_pins[0];
        ln_d.slot.idx = 2'h0;
        ln_d.slot.vld = (cnt_l != SGP_CNT_NONE);
        ln_d.frm = (per_l == SGP_FWD_PER_ONE) ? 3'h0 : SGP_FRM_STEP;
      end else begin
        ln_d.slot.level = ln_q.shadow[ln_q.frm[1:0]];
        ln_d.slot.idx = ln_q.frm[1:0];
        ln_d.slot.vld = (ln_q.frm < cnt_l);
        ln_d.frm = (ln_q.frm + SGP_FRM_STEP == per_l) ? 3'h0 : ln_q.frm + SGP_FRM_STEP;
      end
    end

    if (bck_frame.vld) begin
      ln_d.rmt = bck_frame.pins;
    end
  end

  always_ff @(posedge lnk_clk or negedge arst_n) begin
    if (!arst_n) begin
      ln_q <= '0;
    end else begin
      ln_q <= ln_d;
    end
  end

  assign fwd_slot = ln_q.slot;

endmodule : sgp_port

// ==== verif/sgp_port_properties.sv ====
// Timing checker for the serializer pin port.
`timescale 1ns/1ps
module sgp_port_properties
  import sgp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic lnk_clk,
  input sgp_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvld,
  input wire logic [3:0] pin_i,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [1:0] volt_sense_en,
  input wire logic [2:0] mode_strap,
  input sgp_clk_mode_t clk_mode,
  input wire logic fwd_frame_tick,
  input sgp_fwd_slot_t fwd_slot,
  input sgp_bck_frame_t bck_frame
);
  // ==========================================================================
  // Cycles since reset release, saturating.
  // ==========================================================================
  logic [2:0] rel_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rel_q <= 3'h0;
    end else if (rel_q != 3'h7) begin
      rel_q <= rel_q + 3'h1;
    end
  end
  // ==========================================================================
  // Properties.
  // ==========================================================================
  property p_rvld_after_re;
    @(posedge mclk) disable iff (!arst_n) reg_req.re |=> reg_rvld;
  endproperty
  a_rvld_after_re: assert property (p_rvld_after_re) else $error("read not answered");
  property p_level_upper;
    @(posedge mclk) disable iff (!arst_n)
      (reg_req.re && reg_req.addr == SGP_ADDR_PIN_LEVEL) |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_level_upper: assert property (p_level_upper) else $error("level upper bits set");
  property p_oe_follows_dir;
    @(posedge mclk) disable iff (!arst_n)
      (reg_req.we && reg_req.addr == SGP_ADDR_DIR_CTRL) ##1
      !(reg_req.we && reg_req.addr == SGP_ADDR_DIR_CTRL) |=> pin_oe == $past(reg_req.wdata[7:4], 2);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("enable mismatch");
  property p_local_drive;
    @(posedge mclk) disable iff (!arst_n)
      (reg_req.we && reg_req.addr == SGP_ADDR_LOCAL_DATA && reg_req.wdata[7:4] == 4'h0) ##1
      !(reg_req.we && reg_req.addr == SGP_ADDR_LOCAL_DATA) |=> pin_o == $past(reg_req.wdata[3:0], 2);
  endproperty
  a_local_drive: assert property (p_local_drive) else $error("local drive mismatch");
  property p_sense_off_out;
    @(posedge mclk) disable iff (!arst_n)
      (pin_oe[1:0] & $past(pin_oe[1:0]) & volt_sense_en) == 2'h0;
  endproperty
  a_sense_off_out: assert property (p_sense_off_out) else $error("sense on driven pin");
  property p_strap_decode;
    @(posedge mclk) disable iff (!arst_n)
      rel_q == 3'h6 |-> clk_mode == (mode_strap == SGP_STRAP_SYNC ? SGP_CLK_SYNC :
        (mode_strap == SGP_STRAP_DVP ? SGP_CLK_DVP : SGP_CLK_NONSYNC));
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("mode decode wrong");
  property p_mode_stable;
    @(posedge mclk) disable iff (!arst_n) rel_q == 3'h7 |-> $stable(clk_mode);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed");
  property p_slot_hold;
    @(posedge lnk_clk) disable iff (!arst_n)
      (!$past(fwd_frame_tick) && !$past(fwd_frame_tick, 2)) |-> $stable(fwd_slot);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot moved without frame");
  property p_pin_order;
    @(posedge lnk_clk) disable iff (!arst_n)
      (fwd_slot.vld && fwd_slot.idx != 2'h0 && $changed(fwd_slot.idx))
      |-> fwd_slot.idx == $past(fwd_slot.idx) + 2'h1;
  endproperty
  a_pin_order: assert property (p_pin_order) else $error("pin order broken");
endmodule : sgp_port_properties

bind sgp_port sgp_port_properties u_props (.mclk(mclk), .arst_n(arst_n), .lnk_clk(lnk_clk),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvld(reg_rvld), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe(pin_oe), .volt_sense_en(volt_sense_en), .mode_strap(mode_strap), .clk_mode(clk_mode),
  .fwd_frame_tick(fwd_frame_tick), .fwd_slot(fwd_slot), .bck_frame(bck_frame));

// ==== verif/sgp_remote_model.sv ====
// Remote deserializer model: frame timing and back-link pin channels.
`timescale 1ns/1ps
module sgp_remote_model
  import sgp_pkg::*;
(
  input wire logic lnk_clk,
  input wire logic arst_n,
  input wire logic [3:0] bck_pins,
  output logic fwd_frame_tick,
  output sgp_bck_frame_t bck_frame
);
  logic [5:0] fc_q;
  logic [4:0] bc_q;
  always_ff @(posedge lnk_clk or negedge arst_n) begin
    if (!arst_n) begin
      fc_q <= 6'h00;
      bc_q <= 5'h00;
      fwd_frame_tick <= 1'b0;
      bck_frame <= '0;
    end else begin
      fc_q <= (fc_q == 6'(SGP_FWD_FRAME_BITS - 1)) ? 6'h00 : fc_q + 6'h01;
      bc_q <= (bc_q == 5'(SGP_BCK_FRAME_BITS - 1)) ? 5'h00 : bc_q + 5'h01;
      fwd_frame_tick <= (fc_q == 6'(SGP_FWD_FRAME_BITS - 1));
      bck_frame.vld <= (bc_q == 5'(SGP_BCK_FRAME_BITS - 1));
      // Remote side sends the pin levels once per back frame; between frames the lanes carry junk.
      bck_frame.pins <= (bc_q == 5'(SGP_BCK_FRAME_BITS - 1)) ? bck_pins : ~bck_pins;
    end
  end
endmodule : sgp_remote_model

// ==== verif/sgp_tb.sv ====
// Self-checking bench for the serializer pin port.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb
  import sgp_pkg::*;
;
  logic mclk, lnk_clk, arst_n, tick;
  logic [2:0] mode_strap;
  logic [3:0] ext, rpins, pin_o, pin_oe, pin_w;
  logic [7:0] rdata, rd;
  logic rvld;
  logic [1:0] sense;
  int error_cnt, samples_checked;
  sgp_reg_req_t req;
  sgp_clk_mode_t mode;
  sgp_fwd_slot_t slot;
  sgp_bck_frame_t bck;
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & ext);
  sgp_port dut (.mclk(mclk), .arst_n(arst_n), .lnk_clk(lnk_clk), .reg_req(req),
    .reg_rdata(rdata), .reg_rvld(rvld), .pin_i(pin_w), .pin_o(pin_o), .pin_oe(pin_oe),
    .volt_sense_en(sense), .mode_strap(mode_strap), .clk_mode(mode),
    .fwd_frame_tick(tick), .fwd_slot(slot), .bck_frame(bck));
  sgp_remote_model u_remote (.lnk_clk(lnk_clk), .arst_n(arst_n), .bck_pins(rpins),
    .fwd_frame_tick(tick), .bck_frame(bck));
  // ==========================================================================
  // Clocks, bus tasks and closing.
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    lnk_clk = 1'b0;
    #1.7;
    forever #3 lnk_clk = ~lnk_clk;
  end
  task test_done;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk); req.we = 1'b1; req.addr = a; req.wdata = d;
    @(negedge mclk); req.we = 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a);
    @(negedge mclk); req.re = 1'b1; req.addr = a;
    @(negedge mclk);
    `CHK(rvld, 1'b1)
    rd = rdata;
    req.re = 1'b0;
  endtask : reg_rd
  task do_reset(input logic [2:0] s);
    @(negedge mclk);
    arst_n = 1'b0;
    mode_strap = s;
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask : do_reset
  task get_slot;
    int i;
    for (i = 0; i < 100 && tick !== 1'b1; i++) @(posedge lnk_clk);
    if (i == 100) begin error_cnt++; test_done(); end
    repeat (2) @(posedge lnk_clk);
    #1;
  endtask : get_slot
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task t_strap;
    logic [2:0] s [3] = '{3'h5, 3'h2, 3'h0};
    sgp_clk_mode_t m [3] = '{SGP_CLK_DVP, SGP_CLK_NONSYNC, SGP_CLK_SYNC};
    for (int k = 0; k < 3; k++) begin
      do_reset(s[k]);
      `CHK(mode, m[k])
    end
  endtask : t_strap
  task t_regs;
    ext = 4'hA;
    reg_rd(SGP_ADDR_DIR_CTRL);
    `CHK(rd, 8'h0F)
    `CHK(pin_oe, 4'h0)
    reg_rd(SGP_ADDR_PIN_LEVEL);
    `CHK(rd, 8'h0A)
    reg_wr(SGP_ADDR_PIN_LEVEL, 8'hFF);
    reg_rd(8'h77);
    `CHK(rd, 8'h00)
  endtask : t_regs
  task t_out;
    reg_wr(SGP_ADDR_LOCAL_DATA, 8'h05);
    reg_wr(SGP_ADDR_DIR_CTRL, 8'hF0);
    @(negedge mclk);
    `CHK(pin_oe, 4'hF)
    `CHK(pin_o, 4'h5)
    repeat (4) @(negedge mclk);
    reg_rd(SGP_ADDR_PIN_LEVEL);
    `CHK(rd, 8'h05)
  endtask : t_out
  task t_sense;
    reg_wr(SGP_ADDR_SENSE_CTRL, 8'h03);
    reg_wr(SGP_ADDR_DIR_CTRL, 8'h10);
    repeat (2) @(negedge mclk);
    `CHK(sense, 2'h2)
  endtask : t_sense
  task t_remote;
    int i;
    rpins = 4'h6;
    reg_wr(SGP_ADDR_LOCAL_DATA, 8'hF0);
    reg_wr(SGP_ADDR_DIR_CTRL, 8'hF0);
    for (i = 0; i < 14 && pin_o !== 4'h6; i++) @(negedge mclk);
    `CHK(pin_o, 4'h6)
  endtask : t_remote
  task t_fwd(input logic [2:0] cnt, input int exp_vld);
    int n;
    n = 0;
    ext = 4'h6;
    reg_wr(SGP_ADDR_DIR_CTRL, 8'h0F);
    reg_wr(SGP_ADDR_FWD_CFG, {5'h00, cnt});
    repeat (12) get_slot();
    for (int k = 0; k < 10; k++) begin
      get_slot();
      if (slot.vld === 1'b1) begin
        n++;
        `CHK(slot.level, ext[slot.idx])
      end else begin
        `CHK(slot.vld, 1'b0)
      end
    end
    `CHK(n, exp_vld)
  endtask : t_fwd
  task t_bck_rate(input logic [2:0] strap, input int exp_cyc);
    int i;
    int gap;
    do_reset(strap);
    rpins = 4'h3;
    reg_wr(SGP_ADDR_LOCAL_DATA, 8'hF0);
    reg_wr(SGP_ADDR_DIR_CTRL, 8'hF0);
    for (i = 0; i < 300 && pin_o !== 4'h3; i++) @(negedge mclk);
    rpins = 4'hC;
    for (i = 0; i < 300 && pin_o !== 4'hC; i++) @(negedge mclk);
    rpins = 4'h3;
    for (gap = 0; gap < 300 && pin_o !== 4'h3; gap++) @(negedge mclk);
    `CHK(pin_o, 4'h3)
    `CHK(gap, exp_cyc)
  endtask : t_bck_rate
  initial begin
    req = '0;
    ext = 4'h0;
    rpins = 4'h0;
    arst_n = 1'b0;
    mode_strap = 3'h0;
    error_cnt = 0;
    samples_checked = 0;
    t_strap();
    t_regs();
    t_out();
    t_sense();
    t_remote();
    t_fwd(3'h0, 0);
    t_fwd(3'h1, 10);
    t_fwd(3'h2, 10);
    t_fwd(3'h3, 6);
    t_fwd(3'h4, 8);
    t_bck_rate(3'h2, int'(SGP_BCK_NONSYNC_CYC));
    t_bck_rate(3'h5, int'(SGP_BCK_DVP_CYC));
    test_done();
  end
  initial begin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
endmodule : tb
